// ---- pkg/fan_alarm_pkg.sv ----
// Purpose: Types shared by the fan stepping and alarm logic
// Assumes: Constants live in fan_alarm_regs.svh
// Notes:   States only
package fan_alarm_pkg;
  typedef enum logic [1:0]
  {
    ST_TRACK = 2'b00,
    ST_HOLD  = 2'b01,
    ST_STOP  = 2'b10
  } step_state_e;
endpackage

// ---- pkg/fan_alarm_regs.svh ----
// Purpose: Register offsets, field positions, reset values and timing constants
// Assumes: 8-bit register port, 25 MHz mclk
// Notes:   Offsets are byte indexes on the plain register port
`ifndef FAN_ALARM_REGS_SVH
`define FAN_ALARM_REGS_SVH

`define OFS_PROC_OUT        8'h03
`define OFS_CHAS_TARGET     8'h05
`define OFS_PROC_TARGET     8'h06
`define OFS_TOL_PAIR        8'h07
`define OFS_CHAS_STOP_VAL   8'h08
`define OFS_PROC_STOP_VAL   8'h09
`define OFS_CHAS_START_VAL  8'h0a
`define OFS_PROC_START_VAL  8'h0b
`define OFS_CHAS_STOP_TIME  8'h0c
`define OFS_PROC_STOP_TIME  8'h0d
`define OFS_STEP_TIME_A     8'h0e
`define OFS_STEP_TIME_B     8'h0f
`define OFS_KEEP_MIN        8'h12
`define OFS_ALARM_CFG       8'h29
`define OFS_VOLT_STATUS     8'h41
`define OFS_MISC_STATUS     8'h42
`define OFS_CHAS_TO         8'h39
`define OFS_CHAS_HYST       8'h3a
`define OFS_FAN_CTRL        8'h49
`define OFS_PROC_TEMP_HI    8'h50
`define OFS_PROC_TEMP_LO    8'h51
`define OFS_PROC_MAX_OUT    8'h67
`define OFS_PROC_OUT_STEP   8'h68

`define BIT_PROC_KEEP_MIN   4
`define BIT_CHAS_KEEP_MIN   5
`define BIT_ALARM_SEL       6
`define BIT_STEP_MODE_EN    3
`define RST_OUT_VALUE       8'hff
`define RST_MAX_OUT         8'hff
`define RST_OUT_STEP        8'h01
`define RST_STEP_TIME       8'h0a
`define RST_HYST_MAX        8'h7f
`define RST_CHAS_TO         8'h50
`define RST_ZERO            8'h00

// One step-time unit is 100 ms
`define TICK_TIME_NS        100000000
`define MCLK_PERIOD_NS      40
`define TICK_CYCLES         (`TICK_TIME_NS / `MCLK_PERIOD_NS)

`endif

// ---- verification/fan_env_model.sv ----
// Purpose: Stand-in for the temperature sources, fan comparators and voltage comparators
// Assumes: Bench sets the *_n fields between clock edges
// Notes:   Values launch on the rising edge, as synchronised sensor words would
module fan_env_model
(
  input  wire logic        mclk,
  output logic [63:0]      temp_src,
  output logic [8:0]       proc_temp_input,
  output logic [7:0]       chassis_temp_input,
  output logic [7:0]       volt_high,
  output logic [7:0]       volt_low,
  output logic [1:0]       fan_over
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  src_n = 8'h00;
  logic [7:0]  chas_n = 8'h00;
  logic [7:0]  vh_n = 8'h00;
  logic [7:0]  vl_n = 8'h00;
  logic [1:0]  fan_n = 2'b00;
  logic [33:0] cur = '0;
  // All sensor words except proc_temp_input, which is fixed, change together just after the edge
  always @(posedge mclk)
  begin
    cur <= {src_n, chas_n, vh_n, vl_n, fan_n};
  end
  // Only selector one carries the loop temperature; selectors two to seven read cold
  assign temp_src = {48'h0, cur[33:26], 8'h00};
  assign proc_temp_input = 9'h15b;
  assign chassis_temp_input = cur[25:18];
  assign volt_high = cur[17:10];
  assign volt_low = cur[9:2];
  assign fan_over = cur[1:0];
endmodule

// ---- verification/fan_step_alarm_checker.sv ----
// Purpose: Port-level assertions for the fan stepping and alarm block
// Assumes: One mclk domain, synchronous active-low reset
// Notes:   Shadows a few config writes to know which mode is active
`include "fan_alarm_regs.svh"
module fan_step_alarm_checker
#(
  parameter int NUM_VOLT = 8
)(
  input wire logic                mclk,
  input wire logic                reset_n,
  input wire logic [7:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata,
  input wire logic [7:0]          chassis_temp_input,
  input wire logic [NUM_VOLT-1:0] volt_high,
  input wire logic [7:0]          proc_fan_drive,
  input wire logic                mgmt_irq_n,
  input wire logic                overtemp_out_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [7:0] max_q;
  logic [7:0] to_q;
  logic       sel_q;
  logic [2:0] en_q;
  logic [2:0] wr_q;
  wire        wr_hit = reg_wr && (reg_addr == `OFS_FAN_CTRL);
  // Histories cover the one-cycle lag of the drive pin behind fan-control and output-register writes
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      max_q <= `RST_MAX_OUT;
      to_q <= `RST_CHAS_TO;
      sel_q <= 1'b0;
      en_q <= 3'b000;
      wr_q <= 3'b000;
    end
    else
    begin
      if (reg_wr && reg_addr == `OFS_PROC_MAX_OUT) max_q <= reg_wdata;
      if (reg_wr && reg_addr == `OFS_CHAS_TO) to_q <= reg_wdata;
      if (reg_wr && reg_addr == `OFS_ALARM_CFG) sel_q <= reg_wdata[`BIT_ALARM_SEL];
      en_q <= {en_q[1:0], wr_hit ? reg_wdata[`BIT_STEP_MODE_EN] : en_q[0]};
      wr_q <= {wr_q[1:0], reg_wr && reg_addr == `OFS_PROC_OUT};
    end
  end
  rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside the answer cycle");
  unmapped_zero_a: assert property (reg_rd && reg_addr > 8'h68 |=> reg_rdata == 8'h00)
    else $error("unmapped offset read back nonzero");
  pins_exclusive_a: assert property (mgmt_irq_n || overtemp_out_n)
    else $error("alarm pin active in both functions");
  drive_idle_a: assert property (en_q == 3'b000 && wr_q == 3'b000 |-> $stable(proc_fan_drive))
    else $error("fan drive moved with stepping off");
  step_max_a: assert property (en_q[0] && wr_q == 3'b000 && proc_fan_drive > $past(proc_fan_drive)
    |-> proc_fan_drive <= max_q)
    else $error("fan drive stepped above maximum");
  volt_irq_a: assert property (sel_q && mgmt_irq_n && $rose(volt_high[0]) |-> ##[1:3] !mgmt_irq_n)
    else $error("voltage event raised no interrupt");
  irq_holds_a: assert property (sel_q && !mgmt_irq_n && !reg_rd && !$past(reg_rd) |=> !mgmt_irq_n)
    else $error("interrupt cleared without status reads");
  ovt_level_a: assert property ((!sel_q && chassis_temp_input > to_q) [*3] |-> !overtemp_out_n)
    else $error("over-temperature pin not asserted");
  reset_state_a: assert property ($rose(reset_n) |-> proc_fan_drive == 8'hff && mgmt_irq_n)
    else $error("outputs wrong after reset");
endmodule

bind fan_step_alarm fan_step_alarm_checker #(.NUM_VOLT(NUM_VOLT)) u_chk
(
  .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chassis_temp_input(chassis_temp_input),
  .volt_high(volt_high), .proc_fan_drive(proc_fan_drive), .mgmt_irq_n(mgmt_irq_n),
  .overtemp_out_n(overtemp_out_n)
);

// ---- verification/fan_step_alarm_tb.sv ----
// Purpose: Self-checking bench for the fan stepping and alarm block
// Assumes: TICK_DIV shortened to 4 mclk cycles per step-time unit
// Notes:   Strobes are one cycle; read data is taken in the cycle after the strobe
`include "fan_alarm_regs.svh"
module fan_step_alarm_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata, chassis_temp_input, volt_high, volt_low, proc_fan_drive;
  logic [63:0] temp_src;
  logic [8:0]  proc_temp_input;
  logic [1:0]  fan_over;
  logic        mgmt_irq_n, overtemp_out_n;
  int          bad_count = 0;
  int          n_tests = 0;
  logic [7:0]  ofs_t [8] = '{8'h03, 8'h67, 8'h68, 8'h0e, 8'h0f, 8'h39, 8'h3a, 8'h80};
  logic [7:0]  rst_t [8] = '{8'hff, 8'hff, 8'h01, 8'h0a, 8'h0a, 8'h50, 8'h7f, 8'h00};
  logic [7:0]  rw_t [13] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h12,
                             8'h67, 8'h68};
  logic [15:0] cfg_t [10] = '{16'h0628, 16'h0720, 16'h0e00, 16'h0f00, 16'h0d00, 16'h1200, 16'h6770, 16'h6810,
                              16'h0340, 16'h4909};
  `define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); end end

  always #20 mclk = ~mclk;

  fan_env_model ENV (.mclk(mclk), .temp_src(temp_src), .proc_temp_input(proc_temp_input),
    .chassis_temp_input(chassis_temp_input), .volt_high(volt_high), .volt_low(volt_low), .fan_over(fan_over));
  fan_step_alarm #(.TICK_DIV(4)) DUT (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .temp_src(temp_src),
    .proc_temp_input(proc_temp_input), .chassis_temp_input(chassis_temp_input), .volt_high(volt_high),
    .volt_low(volt_low), .fan_over(fan_over), .proc_fan_drive(proc_fan_drive), .mgmt_irq_n(mgmt_irq_n),
    .overtemp_out_n(overtemp_out_n));

  // Bus cycles launch just after an edge and hold to the sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, exp)
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Bounded wait so a stuck loop shows as a mismatch, not a hang
  task automatic wait_drive(input logic [7:0] exp);
    for (int i = 0; i < 200 && proc_fan_drive !== exp; i++) tick(1);
    `CHK(proc_fan_drive, exp)
  endtask
  task automatic irq_clear(input logic [7:0] v41, input logic [7:0] v42);
    chk_rd(`OFS_VOLT_STATUS, v41);
    chk_rd(`OFS_MISC_STATUS, v42);
    tick(3);
    `CHK(mgmt_irq_n, 1'b1)
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    test_done();
  end

  // Main sequence: registers, stepping loop, then the alarm pin
  initial
  begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) chk_rd(ofs_t[i], rst_t[i]);
    for (int i = 0; i < 13; i++) wr(rw_t[i], 8'h30 + i[7:0]);
    for (int i = 0; i < 13; i++) chk_rd(rw_t[i], 8'h30 + i[7:0]);
    wr(8'h50, 8'h00);
    chk_rd(8'h50, 8'had);
    chk_rd(8'h51, 8'h80);
    ENV.src_n = 8'h28;
    for (int i = 0; i < 10; i++) wr(cfg_t[i][15:8], cfg_t[i][7:0]);
    tick(20);
    `CHK(proc_fan_drive, 8'h40)
    ENV.src_n = 8'h2d;
    wait_drive(8'h60);
    tick(20);
    `CHK(proc_fan_drive, 8'h60)
    ENV.src_n = 8'h64;
    wait_drive(8'h70);
    tick(20);
    `CHK(proc_fan_drive, 8'h70)
    ENV.src_n = 8'h00;
    wait_drive(8'h00);
    wr(8'h12, 8'h10);
    wr(8'h09, 8'h20);
    wr(8'h03, 8'h70);
    wait_drive(8'h20);
    tick(30);
    `CHK(proc_fan_drive, 8'h20)
    wr(8'h0f, 8'h02);
    wr(8'h03, 8'h70);
    wait_drive(8'h60);
    tick(7);
    `CHK(proc_fan_drive, 8'h60)
    wr(8'h49, 8'h00);
    wr(8'h29, 8'h40);
    irq_clear(8'h00, 8'h00);
    ENV.vh_n = 8'h01;
    tick(4);
    `CHK(mgmt_irq_n, 1'b0)
    ENV.vh_n = 8'h00;
    ENV.vl_n = 8'h04;
    tick(2);
    ENV.vl_n = 8'h00;
    tick(2);
    chk_rd(`OFS_VOLT_STATUS, 8'h05);
    tick(3);
    `CHK(mgmt_irq_n, 1'b0)
    irq_clear(8'h00, 8'h00);
    ENV.fan_n = 2'b10;
    tick(4);
    `CHK(mgmt_irq_n, 1'b0)
    irq_clear(8'h00, 8'h02);
    ENV.fan_n = 2'b00;
    tick(4);
    `CHK(mgmt_irq_n, 1'b0)
    irq_clear(8'h00, 8'h02);
    ENV.chas_n = 8'h60;
    tick(4);
    `CHK(mgmt_irq_n, 1'b0)
    chk_rd(`OFS_VOLT_STATUS, 8'h00);
    chk_rd(`OFS_MISC_STATUS, 8'h04);
    tick(4);
    `CHK(mgmt_irq_n, 1'b0)
    ENV.chas_n = 8'h30;
    tick(2);
    irq_clear(8'h00, 8'h04);
    wr(8'h29, 8'h00);
    ENV.chas_n = 8'h60;
    tick(4);
    `CHK(overtemp_out_n, 1'b0)
    `CHK(mgmt_irq_n, 1'b1)
    ENV.chas_n = 8'h30;
    tick(4);
    `CHK(overtemp_out_n, 1'b1)
    // Two-times mode: one interrupt on rising above, none while above, one on falling below
    wr(8'h29, 8'h40);
    irq_clear(8'h00, 8'h04);
    wr(8'h3a, 8'h40);
    ENV.chas_n = 8'h60;
    tick(4);
    `CHK(mgmt_irq_n, 1'b0)
    irq_clear(8'h00, 8'h04);
    tick(4);
    `CHK(mgmt_irq_n, 1'b1)
    ENV.chas_n = 8'h30;
    tick(4);
    `CHK(mgmt_irq_n, 1'b0)
    irq_clear(8'h00, 8'h04);
    test_done();
  end
endmodule

// ---- verilog/fan_step_alarm.sv ----
// Purpose: Stepping-target fan control for the processor fan and the alarm pin
// Assumes: Temperatures and counts arrive as synchronous words on mclk
// Notes:   Parameter map of the other fan modes is storage only
// Overview of operation
// - Stepping mode drives only processor fan, source picked by three-bit selector.
// - Temperature inside target plus or minus tolerance holds output.
// - Above target plus tolerance: one step up, target moves up by tolerance.
// - Upward stepping repeats and stops at the programmed maximum output.
// - Below target minus tolerance: one step down, target down, until minimum.
// - Staying low ramps to zero, or to stop value with keep-minimum set.
// - At stop value the output holds for the programmed stop time.
// - Step size comes from the output-step register.
// - Target, tolerance, stop, maximum, times, step and keep-minimum are programmable.
// - Tracking mode keeps per-channel target, start, stop, stop time, keep-minimum.
// - Speed-holding mode reuses target, tolerance nibble, keep bit, step times.
// - Alarm pin is management interrupt when select bit set, else overtemp.
// - Voltage above high or below low limit raises the interrupt.
// - Fan count crossing its limit either way raises the interrupt.
// - Reading all status registers clears; no new events signal until then.
// - Chassis temperature comparator mode when hysteresis is at maximum code.
// - Comparator mode interrupts while above threshold, again after each clear.
// - Two-times mode interrupts on rising above threshold and below hysteresis.
//
// Strobed register access was left to the implementer.
`include "fan_alarm_regs.svh"
module fan_step_alarm
  import fan_alarm_pkg::*;
#(
  parameter int NUM_VOLT     = 8,
  parameter int NUM_FAN      = 2,
  parameter int NUM_TEMP_SRC = 8,
  parameter int TICK_DIV     = `TICK_CYCLES
)(
  input  wire logic                    mclk,
  input  wire logic                    reset_n,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [7:0]                   reg_rdata,
  input  wire logic [NUM_TEMP_SRC*8-1:0] temp_src,
  input  wire logic [8:0]              proc_temp_input,
  input  wire logic [7:0]              chassis_temp_input,
  input  wire logic [NUM_VOLT-1:0]     volt_high,
  input  wire logic [NUM_VOLT-1:0]     volt_low,
  input  wire logic [NUM_FAN-1:0]      fan_over,
  output logic [7:0]                   proc_fan_drive,
  output logic                         mgmt_irq_n,
  output logic                         overtemp_out_n
);
  initial
  begin
    if (NUM_VOLT < 1 || NUM_VOLT > 8) $error("NUM_VOLT must be 1..8");
    if (NUM_FAN < 1 || NUM_FAN > 8) $error("NUM_FAN must be 1..8");
    if (NUM_TEMP_SRC != 8) $error("NUM_TEMP_SRC must be 8");
    if (TICK_DIV < 1) $error("TICK_DIV must be positive");
  end

  // Register storage
  logic [7:0] out_q, out_d;
  logic [7:0] chas_target_q, proc_target_q, tol_pair_q;
  logic [7:0] chas_stop_val_q, proc_stop_val_q, chas_start_q, proc_start_q;
  logic [7:0] chas_stop_time_q, proc_stop_time_q, step_time_a_q, step_time_b_q;
  logic [7:0] keep_min_q, alarm_cfg_q, fan_ctrl_q, max_out_q, out_step_q;
  logic [7:0] chas_to_q, chas_hyst_q;
  logic [7:0] work_target_q, work_target_d;
  logic [7:0] rdata_q;
  step_state_e state_q, state_d;

  // Divider for the 100 ms step-time tick
  logic [31:0] div_q;
  logic        tick_q;
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (div_q == 32'(TICK_DIV - 1));
      div_q  <= (div_q == 32'(TICK_DIV - 1)) ? '0 : div_q + 32'h1;
    end
  end

  // Write decode
  wire wr_out       = reg_wr && reg_addr == `OFS_PROC_OUT;
  wire wr_max       = reg_wr && reg_addr == `OFS_PROC_MAX_OUT;
  wire wr_step      = reg_wr && reg_addr == `OFS_PROC_OUT_STEP;
  wire wr_target    = reg_wr && reg_addr == `OFS_PROC_TARGET;
  wire wr_fan_ctrl  = reg_wr && reg_addr == `OFS_FAN_CTRL;

  // Controls decoded from software registers
  wire       mode_en   = fan_ctrl_q[`BIT_STEP_MODE_EN];
  wire [2:0] src_sel   = fan_ctrl_q[2:0];
  wire [7:0] tol       = {4'h0, tol_pair_q[7:4]};
  wire       keep_min  = keep_min_q[`BIT_PROC_KEEP_MIN];
  wire [7:0] sel_temp  = (src_sel == 3'h0) ? proc_temp_input[8:1] : temp_src[src_sel*8 +: 8];
  wire [8:0] hi_bound  = {1'b0, work_target_q} + {1'b0, tol};
  wire [8:0] lo_bound  = {1'b0, work_target_q} - {1'b0, tol};
  wire       too_hot   = {1'b0, sel_temp} > hi_bound;
  wire       too_cold  = !lo_bound[8] && sel_temp < lo_bound[7:0];
  wire [7:0] floor_val = keep_min ? proc_stop_val_q : `RST_ZERO;
  wire [8:0] up_sum    = {1'b0, out_q} + {1'b0, out_step_q};
  wire [7:0] up_val    = (up_sum > {1'b0, max_out_q}) ? max_out_q : up_sum[7:0];
  wire [8:0] dn_diff   = {1'b0, out_q} - {1'b0, out_step_q};
  wire [7:0] dn_val    = (dn_diff[8] || dn_diff[7:0] < floor_val) ? floor_val : dn_diff[7:0];

  // Step pacing timers and stop-time hold timer
  logic up_ready, dn_ready, stop_done;
  logic up_load, dn_load, stop_load;
  tick_timer #(.WIDTH(8)) up_timer
  (
    .mclk    (mclk),
    .reset_n (reset_n),
    .load    (up_load),
    .value   (step_time_a_q),
    .tick    (tick_q),
    .done    (up_ready)
  );
  tick_timer #(.WIDTH(8)) dn_timer
  (
    .mclk    (mclk),
    .reset_n (reset_n),
    .load    (dn_load),
    .value   (step_time_b_q),
    .tick    (tick_q),
    .done    (dn_ready)
  );
  tick_timer #(.WIDTH(8)) stop_timer
  (
    .mclk    (mclk),
    .reset_n (reset_n),
    .load    (stop_load),
    .value   (proc_stop_time_q),
    .tick    (tick_q),
    .done    (stop_done)
  );

  wire can_up   = mode_en && state_q != ST_STOP && too_hot && up_ready && out_q < max_out_q;
  wire can_dn   = mode_en && state_q != ST_STOP && too_cold && dn_ready && out_q > floor_val;
  assign up_load   = can_up;
  assign dn_load   = can_dn;
  assign stop_load = can_dn && dn_val == floor_val && keep_min;

  // Stepping controller: one step per paced opportunity
  always_comb
  begin
    out_d         = out_q;
    work_target_d = work_target_q;
    state_d       = state_q;
    unique case (state_q)
      ST_TRACK, ST_HOLD:
      begin
        if (can_up)
        begin
          out_d         = up_val;
          work_target_d = hi_bound[8] ? 8'hff : hi_bound[7:0];
          state_d       = ST_TRACK;
        end
        else if (can_dn)
        begin
          out_d         = dn_val;
          work_target_d = lo_bound[7:0];
          state_d       = stop_load ? ST_STOP : ST_TRACK;
        end
        else if (!too_hot && !too_cold)
          state_d = ST_HOLD;
      end
      ST_STOP:
      begin
        if (stop_done || !too_cold || !mode_en)
          state_d = ST_TRACK;
      end
      default: state_d = ST_TRACK;
    endcase
  end

  // Register writes; software write to output or target reseeds the loop
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      out_q         <= `RST_OUT_VALUE;
      work_target_q <= `RST_ZERO;
      state_q       <= ST_TRACK;
    end
    else
    begin
      out_q         <= wr_out ? reg_wdata : out_d;
      work_target_q <= wr_target ? reg_wdata : (!mode_en ? proc_target_q : work_target_d);
      state_q       <= (wr_out || wr_target || wr_fan_ctrl) ? ST_TRACK : state_d;
    end
  end

  // Parameter map for all fan modes
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      chas_target_q <= `RST_ZERO;
      proc_target_q <= `RST_ZERO;
      tol_pair_q <= `RST_ZERO;
      chas_stop_val_q <= `RST_ZERO;
      proc_stop_val_q <= `RST_ZERO;
      chas_start_q <= `RST_ZERO;
      proc_start_q <= `RST_ZERO;
      chas_stop_time_q <= `RST_ZERO;
      proc_stop_time_q <= `RST_ZERO;
      step_time_a_q <= `RST_STEP_TIME;
      step_time_b_q <= `RST_STEP_TIME;
      keep_min_q <= `RST_ZERO;
      alarm_cfg_q <= `RST_ZERO;
      fan_ctrl_q <= `RST_ZERO;
      max_out_q <= `RST_MAX_OUT;
      out_step_q <= `RST_OUT_STEP;
      chas_to_q <= `RST_CHAS_TO;
      chas_hyst_q <= `RST_HYST_MAX;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `OFS_CHAS_TARGET:    chas_target_q <= reg_wdata;
        `OFS_PROC_TARGET:    proc_target_q <= reg_wdata;
        `OFS_TOL_PAIR:       tol_pair_q <= reg_wdata;
        `OFS_CHAS_STOP_VAL:  chas_stop_val_q <= reg_wdata;
        `OFS_PROC_STOP_VAL:  proc_stop_val_q <= reg_wdata;
        `OFS_CHAS_START_VAL: chas_start_q <= reg_wdata;
        `OFS_PROC_START_VAL: proc_start_q <= reg_wdata;
        `OFS_CHAS_STOP_TIME: chas_stop_time_q <= reg_wdata;
        `OFS_PROC_STOP_TIME: proc_stop_time_q <= reg_wdata;
        `OFS_STEP_TIME_A:    step_time_a_q <= reg_wdata;
        `OFS_STEP_TIME_B:    step_time_b_q <= reg_wdata;
        `OFS_KEEP_MIN:       keep_min_q <= reg_wdata;
        `OFS_ALARM_CFG:      alarm_cfg_q <= reg_wdata;
        `OFS_FAN_CTRL:       fan_ctrl_q <= reg_wdata;
        `OFS_PROC_MAX_OUT:   max_out_q <= reg_wdata;
        `OFS_PROC_OUT_STEP:  out_step_q <= reg_wdata;
        `OFS_CHAS_TO:        chas_to_q <= reg_wdata;
        `OFS_CHAS_HYST:      chas_hyst_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Alarm events: voltage, fan limit crossings, chassis temperature
  logic [NUM_FAN-1:0] fan_over_q;
  logic               chas_hot_q;
  logic [7:0]         volt_stat_q;
  logic [7:0]         misc_stat_q;
  logic               irq_q, irq_armed_q, read_v_q, read_m_q;
  wire comparator_mode = (chas_hyst_q == `RST_HYST_MAX);
  wire chas_above  = chassis_temp_input > chas_to_q;
  wire chas_below  = chassis_temp_input < chas_hyst_q;
  wire chas_rise   = !comparator_mode && chas_above && !chas_hot_q;
  wire chas_fall   = !comparator_mode && chas_below && chas_hot_q;
  wire chas_cmp    = comparator_mode && chas_above;
  wire [NUM_FAN-1:0] fan_cross = fan_over ^ fan_over_q;
  wire [7:0] volt_ev = 8'(volt_high | volt_low);
  wire [7:0] misc_ev = {5'h0, chas_cmp | chas_rise | chas_fall, 2'h0} | 8'(fan_cross);
  wire rd_volt     = reg_rd && reg_addr == `OFS_VOLT_STATUS;
  wire rd_misc     = reg_rd && reg_addr == `OFS_MISC_STATUS;
  wire all_read    = (read_v_q || rd_volt) && (read_m_q || rd_misc);
  wire any_ev      = |volt_ev || |misc_ev;

  // Sticky status; an event in the clearing read's cycle still sets
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      fan_over_q  <= '0;
      chas_hot_q  <= 1'b0;
      volt_stat_q <= `RST_ZERO;
      misc_stat_q <= `RST_ZERO;
      read_v_q    <= 1'b0;
      read_m_q    <= 1'b0;
      irq_q       <= 1'b0;
      irq_armed_q <= 1'b1;
    end
    else
    begin
      fan_over_q  <= fan_over;
      chas_hot_q  <= chas_rise ? 1'b1 : (chas_fall ? 1'b0 : chas_hot_q);
      volt_stat_q <= (rd_volt ? `RST_ZERO : volt_stat_q) | volt_ev;
      misc_stat_q <= (rd_misc ? `RST_ZERO : misc_stat_q) | misc_ev;
      read_v_q    <= all_read ? 1'b0 : (irq_q && (read_v_q || rd_volt));
      read_m_q    <= all_read ? 1'b0 : (irq_q && (read_m_q || rd_misc));
      if (irq_q && all_read)
      begin
        irq_q       <= any_ev;
        irq_armed_q <= !any_ev;
      end
      else if (irq_armed_q && any_ev)
      begin
        irq_q       <= 1'b1;
        irq_armed_q <= 1'b0;
      end
    end
  end

  // Read mux; unmapped offsets read zero
  logic [7:0] rmux;
  always_comb
  begin
    unique case (reg_addr)
      `OFS_PROC_OUT:       rmux = out_q;
      `OFS_CHAS_TARGET:    rmux = chas_target_q;
      `OFS_PROC_TARGET:    rmux = proc_target_q;
      `OFS_TOL_PAIR:       rmux = tol_pair_q;
      `OFS_CHAS_STOP_VAL:  rmux = chas_stop_val_q;
      `OFS_PROC_STOP_VAL:  rmux = proc_stop_val_q;
      `OFS_CHAS_START_VAL: rmux = chas_start_q;
      `OFS_PROC_START_VAL: rmux = proc_start_q;
      `OFS_CHAS_STOP_TIME: rmux = chas_stop_time_q;
      `OFS_PROC_STOP_TIME: rmux = proc_stop_time_q;
      `OFS_STEP_TIME_A:    rmux = step_time_a_q;
      `OFS_STEP_TIME_B:    rmux = step_time_b_q;
      `OFS_KEEP_MIN:       rmux = keep_min_q;
      `OFS_ALARM_CFG:      rmux = alarm_cfg_q;
      `OFS_FAN_CTRL:       rmux = fan_ctrl_q;
      `OFS_PROC_MAX_OUT:   rmux = max_out_q;
      `OFS_PROC_OUT_STEP:  rmux = out_step_q;
      `OFS_CHAS_TO:        rmux = chas_to_q;
      `OFS_CHAS_HYST:      rmux = chas_hyst_q;
      `OFS_VOLT_STATUS:    rmux = volt_stat_q;
      `OFS_MISC_STATUS:    rmux = misc_stat_q;
      `OFS_PROC_TEMP_HI:   rmux = proc_temp_input[8:1];
      `OFS_PROC_TEMP_LO:   rmux = {proc_temp_input[0], 7'h0};
      default:             rmux = `RST_ZERO;
    endcase
  end

  // Registered outputs; alarm pin function chosen by config bit
  logic [7:0] drive_q;
  logic       mgmt_n_q, ovt_n_q;
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      rdata_q  <= `RST_ZERO;
      drive_q  <= `RST_OUT_VALUE;
      mgmt_n_q <= 1'b1;
      ovt_n_q  <= 1'b1;
    end
    else
    begin
      rdata_q  <= reg_rd ? rmux : `RST_ZERO;
      drive_q  <= out_d;
      mgmt_n_q <= !(alarm_cfg_q[`BIT_ALARM_SEL] && irq_q);
      ovt_n_q  <= !(!alarm_cfg_q[`BIT_ALARM_SEL] && chas_above);
    end
  end
  assign reg_rdata      = rdata_q;
  assign proc_fan_drive = drive_q;
  assign mgmt_irq_n     = mgmt_n_q;
  assign overtemp_out_n = ovt_n_q;
endmodule

// ---- verilog/tick_timer.sv ----
// Purpose: Down counter of step-time ticks, reloadable, with done level
// Assumes: tick is a one-cycle enable from the main divider
// Notes:   A load of zero reports done at once
module tick_timer
  import fan_alarm_pkg::*;
#(
  parameter int WIDTH = 8
)(
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] value,
  input  wire logic             tick,
  output logic                  done
);
  initial
  begin
    if (WIDTH < 1) $error("tick_timer WIDTH must be positive");
  end

  logic [WIDTH:0] count_q;

  assign done = (count_q == '0);

  // Load wins over a tick; one extra count since the first tick may come a cycle after the load
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      count_q <= '0;
    else if (load)
      count_q <= (value == '0) ? '0 : {1'b0, value} + 1'b1;
    else if (tick && !done)
      count_q <= count_q - 1'b1;
  end
endmodule
